// [core/comparator_control_wake_map.svh]
// Register offsets, field positions, reset values and patterns of the comparator block
`ifndef COMPARATOR_CONTROL_WAKE_MAP_SVH
`define COMPARATOR_CONTROL_WAKE_MAP_SVH

// Register offsets
`define OFS_STATUS_FLAGS      8'h03
`define OFS_COMPARATOR_CTRL   8'h07
`define OFS_IRQ_STATUS        8'h10
`define OFS_IRQ_CLEAR         8'h11
`define OFS_IRQ_ENABLE        8'h12

// Comparator control register fields
`define CTL_RESULT_BIT        7
`define CTL_PIN_DISABLE_BIT   6
`define CTL_POLARITY_BIT      5
`define CTL_TIMER_SRC_BIT     4
`define CTL_ON_BIT            3
`define CTL_INV_REF_BIT       2
`define CTL_NONINV_REF_BIT    1
`define CTL_WAKE_DIS_BIT      0
`define CTL_RESET_VALUE       8'hff

// Status register fields
`define STS_PIN_WAKE_BIT      7
`define STS_CMP_WAKE_BIT      6
`define STS_TOP_RESET         5'h03
`define STS_TOP_CMP_WAKE      5'h0a
`define STS_TOP_PIN_WAKE      5'h12
`define STS_TOP_WDT_WAKE      5'h00

// Interrupt status fields
`define IRQ_CMP_BIT           0
`define IRQ_PIN_BIT           1
`define IRQ_WDT_BIT           2
`define IRQ_WIDTH             3

`endif

// [core/comparator_control_wake_pkg.sv]
// Types shared by the comparator control and wake logic
package comparator_control_wake_pkg;
    typedef logic [7:0] byte_type;         // One register byte
    typedef enum logic {awake_st, asleep_st} sleep_type;  // Core power state
endpackage

// [core/comparator_sense_if.sv]
// Signals between the register logic and the change detector
`timescale 1ns/1ns
`default_nettype none
interface comparator_sense_if;
    logic live_result;   // Result after polarity
    logic capture;       // Control register read strobe
    logic watch;         // Asleep, powered and wake enabled
    logic changed;       // First mismatch pulse
    logic armed;         // A capture has happened
    logic captured;      // Reference value
    modport ctrl (output live_result, capture, watch, input changed, armed, captured);
    modport det  (input live_result, capture, watch, output changed, armed, captured);
endinterface
`default_nettype wire

// [core/comparator_change_detect.sv]
// Captures the comparator result on read and flags the first change while watched
`timescale 1ns/1ns
`default_nettype none
module comparator_change_detect
(
    input  wire logic           core_clk, // System clock
    input  wire logic           nrst,     // Async reset, active low
    comparator_sense_if.det     sense     // Sense link
);
    logic seen;  // Mismatch already reported

    ////////////////////////////////////////////////////////////////////////////
    // Reference capture on a control read
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sense.captured <= 1'b0;
            sense.armed    <= 1'b0;
        end
        else if (sense.capture)
        begin
            sense.captured <= sense.live_result;  // see R3
            sense.armed    <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare each clock; only the first mismatch pulses
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            seen          <= 1'b0;
            sense.changed <= 1'b0;
        end
        else if (sense.capture)
        begin
            seen          <= 1'b0;  // New reference restarts the watch
            sense.changed <= 1'b0;
        end
        else
        begin
            sense.changed <= sense.watch && sense.armed && !seen && !sense.changed
                             && (sense.live_result != sense.captured);  // see R14
            if (sense.changed)
                seen <= 1'b1;
        end
    end

    a_capture_value: assert property (@(posedge core_clk) disable iff (!nrst) // see R3
        sense.capture |=> sense.captured == $past(sense.live_result))
        else $error("reference not captured on read");
endmodule // comparator_change_detect
`default_nettype wire

// [core/comparator_control_wake.sv]
// Comparator control register, status flags, sleep wake and interrupt logic
// What this block does
// R1: Result is read-only control bit seven
// R2: Wake flag needs enable, read, sleep, change
// R3: Control read captures result as reference
// R4: Wake flag cleared by software or reset
// R5: Comparator stays powered and watched in sleep
// R6: Power-on reset loads control with all ones
// R7: Comparator powered down throughout reset
// R8: Software waits response time after selection change
// R9: Comparator, pin change or watchdog wake core
// R10: Mode routes internal reference to inverting input
// R11: Result high when non-inverting input is higher, unless the polarity bit is cleared
// R12: Timer clock mux: cycle, result or pin
// R13: Comparator wake sets status top to 01010
// R14: First mismatch with captured result while asleep wakes
`timescale 1ns/1ns
`default_nettype none
`include "comparator_control_wake_map.svh"
module comparator_control_wake
(
    input  wire logic                                  core_clk,      // System clock
    input  wire logic                                  nrst,          // Power-on reset, low
    input  wire logic                                  dev_reset,     // Other device reset pulse
    input  wire logic [7:0]                            reg_addr,      // Register address
    input  wire comparator_control_wake_pkg::byte_type reg_wdata,     // Write data
    input  wire logic                                  reg_wr,        // Write strobe
    input  wire logic                                  reg_rd,        // Read strobe
    output var  comparator_control_wake_pkg::byte_type reg_rdata,     // Read data, next cycle
    input  wire logic                                  cmp_raw,       // Analog core decision
    input  wire logic                                  sleep_cmd,     // Enter sleep pulse
    input  wire logic                                  pin_change,    // Input pin change
    input  wire logic                                  wdt_timeout,   // Watchdog time-out
    input  wire logic                                  timer_source_select, // Timer source
    input  wire logic                                  instr_tick,    // Instruction cycle clock
    input  wire logic                                  timer_clock_pin, // Timer clock pin
    output logic                                       comparator_on, // Analog core power
    output logic                                       route_internal_ref, // Inverting ref mux
    output logic                                       noninv_from_pin, // Non-inverting mux
    output logic                                       result_pin_out, // Result pin level
    output logic                                       result_pin_oe, // Result pin drive
    output logic                                       timer_clock,   // Timer zero clock
    output logic                                       asleep,        // Core is asleep
    output logic                                       wake,          // Wake pulse to core
    output logic                                       irq            // Level interrupt
);
    import comparator_control_wake_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    byte_type                  ctrl;          // Control bits 6..0 held here
    logic                      result;        // Live result after polarity
    logic [4:0]                status_top;    // Status bits 7..3
    logic [2:0]                status_low;    // Core arithmetic flags
    sleep_type                 state;         // Sleep state
    logic [`IRQ_WIDTH-1:0]     irq_status;    // Sticky events
    logic [`IRQ_WIDTH-1:0]     irq_enable;    // Event gates
    logic [`IRQ_WIDTH-1:0]     events;        // Event pulses this cycle
    logic                      cmp_wake;      // Comparator change while asleep
    logic                      pin_wake;      // Pin change while asleep
    logic                      wdt_wake;      // Watchdog while asleep
    logic                      any_wake;      // Any wake cause
    logic                      wr_ctrl;       // Write to control
    logic                      wr_status;     // Write to status
    logic                      rd_ctrl;       // Read of control
    byte_type                  next_rdata;    // Read mux
    logic                      next_timer;    // Timer mux
    comparator_sense_if        sense ();      // Detector link

    assign wr_ctrl   = reg_wr && (reg_addr == `OFS_COMPARATOR_CTRL);
    assign wr_status = reg_wr && (reg_addr == `OFS_STATUS_FLAGS);
    assign rd_ctrl   = reg_rd && (reg_addr == `OFS_COMPARATOR_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // Control register; bit 7 never stored from the bus
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            ctrl <= `CTL_RESET_VALUE;  // see R6
        else if (wr_ctrl)
            ctrl <= {1'b1, reg_wdata[6:0]};  // see R1
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result sampling; the analog core is high when its plus input wins
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            result <= 1'b0;
        else if (comparator_on)
            // Polarity set keeps the raw sense, cleared inverts it
            result <= ctrl[`CTL_POLARITY_BIT] ? cmp_raw : !cmp_raw;  // see R11
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog steering; power held off while reset stands
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            comparator_on      <= 1'b0;  // see R7
            route_internal_ref <= 1'b0;
            noninv_from_pin    <= 1'b0;
            result_pin_out     <= 1'b0;
            result_pin_oe      <= 1'b0;
        end
        else if (dev_reset)
        begin
            comparator_on      <= 1'b0;  // see R7
            route_internal_ref <= 1'b0;
            noninv_from_pin    <= 1'b0;
            result_pin_out     <= 1'b0;
            result_pin_oe      <= 1'b0;
        end
        else
        begin
            // Stays on through sleep so the change watch keeps running
            comparator_on      <= ctrl[`CTL_ON_BIT];  // see R5
            // Selection bits only matter while the core is on
            route_internal_ref <= ctrl[`CTL_ON_BIT] && !ctrl[`CTL_INV_REF_BIT];  // see R10
            noninv_from_pin    <= ctrl[`CTL_ON_BIT] && ctrl[`CTL_NONINV_REF_BIT];
            result_pin_out     <= result;
            result_pin_oe      <= ctrl[`CTL_ON_BIT] && !ctrl[`CTL_PIN_DISABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer zero clock source
    always_comb
    begin
        if (!timer_source_select)
            next_timer = instr_tick;
        else if (ctrl[`CTL_TIMER_SRC_BIT] && ctrl[`CTL_PIN_DISABLE_BIT])
            next_timer = timer_clock_pin;
        else
            next_timer = result;  // see R12
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            timer_clock <= 1'b0;
        else
            timer_clock <= next_timer;  // see R12
    end

    ////////////////////////////////////////////////////////////////////////////
    // Change detector; the selection settle wait is software's job
    assign sense.live_result = result;
    assign sense.capture     = rd_ctrl;  // see R3
    assign sense.watch       = (state == asleep_st) && comparator_on
                               && !ctrl[`CTL_WAKE_DIS_BIT];  // see R2 R8

    comparator_change_detect u_detect
    (
        .core_clk (core_clk),
        .nrst     (nrst),
        .sense    (sense.det)
    );

    assign cmp_wake = sense.changed && (state == asleep_st);  // see R2
    assign pin_wake = pin_change && (state == asleep_st);
    assign wdt_wake = wdt_timeout && (state == asleep_st);
    assign any_wake = cmp_wake || pin_wake || wdt_wake;

    ////////////////////////////////////////////////////////////////////////////
    // Sleep state and the wake pulse
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= awake_st;
            wake  <= 1'b0;
        end
        else
        begin
            wake <= any_wake;  // see R9
            case (state)
                awake_st:
                    if (sleep_cmd)
                        state <= asleep_st;
                asleep_st:
                    if (any_wake || dev_reset)
                        state <= awake_st;
                default:
                    state <= awake_st;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            asleep <= 1'b0;
        else
            asleep <= (state == asleep_st) && !any_wake && !dev_reset;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status register: wake causes leave their pattern, set beats clear
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            status_top <= `STS_TOP_RESET;
        else if (cmp_wake)
            status_top <= `STS_TOP_CMP_WAKE;  // see R13
        else if (pin_wake)
            status_top <= `STS_TOP_PIN_WAKE;
        else if (wdt_wake)
            status_top <= `STS_TOP_WDT_WAKE;
        else if (dev_reset)
            status_top <= {2'b00, 1'b0, status_top[1:0]};  // see R4
        else if (wr_status)
            // Only the two wake flags are writable, and only to clear
            status_top <= {status_top[4] & reg_wdata[`STS_PIN_WAKE_BIT],
                           status_top[3] & reg_wdata[`STS_CMP_WAKE_BIT],
                           status_top[2:0]};  // see R4
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            status_low <= 3'h0;
        else if (wr_status)
            status_low <= reg_wdata[2:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, per-bit sticky with set over clear
    assign events = {wdt_wake, pin_wake, cmp_wake};

    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1)
        begin : g_irq
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                    irq_status[gi] <= 1'b0;
                else if (events[gi])
                    irq_status[gi] <= 1'b1;
                else if (reg_wr && (reg_addr == `OFS_IRQ_CLEAR) && reg_wdata[gi])
                    irq_status[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            irq_enable <= '0;
        else if (reg_wr && (reg_addr == `OFS_IRQ_ENABLE))
            irq_enable <= reg_wdata[`IRQ_WIDTH-1:0];
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_enable);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; unmapped and idle cycles return zero
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `OFS_STATUS_FLAGS:    next_rdata = {status_top, status_low};
            `OFS_COMPARATOR_CTRL: next_rdata = {result, ctrl[6:0]};  // see R1
            `OFS_IRQ_STATUS:      next_rdata = {5'h00, irq_status};
            `OFS_IRQ_ENABLE:      next_rdata = {5'h00, irq_enable};
            default:              next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_cmp_change;
        (state == asleep_st) && sense.changed;
    endsequence

    sequence s_wake_once;
        wake ##1 !asleep;
    endsequence

    a_result_readonly: assert property ( // see R1
        rd_ctrl |=> reg_rdata[7] == $past(result))
        else $error("result bit not shown on read");

    a_wake_conditions: assert property ( // see R2
        $rose(status_top[3]) |-> $past(sense.armed && !ctrl[0] && state == asleep_st))
        else $error("wake flag set without its conditions");

    a_flag_clear: assert property ( // see R4
        dev_reset && !cmp_wake |=> !status_top[3])
        else $error("wake flag survived device reset");

    a_power_in_sleep: assert property ( // see R5
        ctrl[3] && !dev_reset && state == asleep_st |=> comparator_on)
        else $error("comparator off during sleep");

    a_reset_power: assert property ( // see R7
        dev_reset |=> !comparator_on)
        else $error("comparator powered in reset");

    a_wake_pulse: assert property ( // see R9
        s_cmp_change |=> s_wake_once)
        else $error("no wake after comparator change");

    a_ref_route: assert property ( // see R10
        !dev_reset |=> route_internal_ref == $past(ctrl[3] && !ctrl[2]))
        else $error("internal reference routing wrong");

    a_timer_pin: assert property ( // see R12
        timer_source_select && ctrl[4] && ctrl[6] |=> timer_clock == $past(timer_clock_pin))
        else $error("timer clock pin not selected");

    a_status_pattern: assert property ( // see R13
        s_cmp_change |=> status_top == 5'h0a)
        else $error("status pattern wrong after comparator wake");

    a_sw_clear: assert property ( // see R4
        wr_status && !reg_wdata[`STS_CMP_WAKE_BIT] && !cmp_wake |=> !status_top[3])
        else $error("wake flag not cleared by software");

    a_wake_disabled: assert property ( // see R2
        $past(ctrl[`CTL_WAKE_DIS_BIT]) |-> !sense.changed)
        else $error("change flagged while wake disabled");
endmodule // comparator_control_wake
`default_nettype wire

// [bench/analog_core_model.sv]
// Behavioural model of the analog comparator core facing the control block
`timescale 1ns/1ns
`default_nettype none
module analog_core_model
(
    input  wire logic       core_clk,    // System clock
    input  wire logic       powered,     // Core power from the block
    input  wire logic       use_int_ref, // Inverting input from internal reference
    input  wire logic [7:0] plus_level,  // Non-inverting input level
    input  wire logic [7:0] pin_level,   // Inverting pin level
    input  wire logic [7:0] ref_level,   // Internal reference level
    output logic            decision     // Raw comparator decision
);
    logic       junk = 1'b0; // Meaningless level while unpowered
    logic [7:0] minus_level; // Selected inverting input

    ////////////////////////////////////////////////////////////////////////////////
    // Unpowered core toggles, so a stale decision never looks valid
    always_ff @(posedge core_clk)
    begin
        junk <= !junk;
    end

    // Reference routing and decision
    always_comb
    begin
        minus_level = use_int_ref ? ref_level : pin_level;
        decision = powered ? (plus_level > minus_level) : junk;
    end
endmodule // analog_core_model
`default_nettype wire

// [bench/comparator_control_wake_test.sv]
// Self-checking testbench of the comparator control and wake block
`timescale 1ns/1ns
`default_nettype none
`include "comparator_control_wake_map.svh"
module comparator_control_wake_test;
    import comparator_control_wake_pkg::*;
    localparam int settle_cycles = 4; // Comparator response allowance
    logic       core_clk, nrst, dev_reset, reg_wr, reg_rd, sleep_cmd; // Driven inputs
    logic       pin_change, wdt_timeout, timer_source_select;          // Wake and mux inputs
    logic       instr_tick, timer_clock_pin, cmp_raw;                  // Clock sources, decision
    logic [7:0] reg_addr, plus_level, pin_level, ref_level;           // Address and levels
    byte_type   reg_wdata, reg_rdata, rd;                             // Bus data
    logic       comparator_on, route_internal_ref, noninv_from_pin;   // Analog controls
    logic       result_pin_out, result_pin_oe, timer_clock;           // Pin and timer
    logic       asleep, wake, irq, seen;                              // Power state
    int         mismatches = 0;  // Failed comparisons
    int         check_count = 0; // All comparisons
    byte_type   t_ctl [5] = '{8'h58, 8'h58, 8'h48, 8'h68, 8'h18}; // Mux table: control
    logic [3:0] t_sel [5] = '{4'hb, 4'h5, 4'he, 4'h9, 4'he};     // tss, instr, pin, expected

    comparator_control_wake comparator_control_wake_inst (.core_clk(core_clk), .nrst(nrst),
        .dev_reset(dev_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw), .sleep_cmd(sleep_cmd),
        .pin_change(pin_change), .wdt_timeout(wdt_timeout),
        .timer_source_select(timer_source_select), .instr_tick(instr_tick),
        .timer_clock_pin(timer_clock_pin), .comparator_on(comparator_on),
        .route_internal_ref(route_internal_ref), .noninv_from_pin(noninv_from_pin),
        .result_pin_out(result_pin_out), .result_pin_oe(result_pin_oe),
        .timer_clock(timer_clock), .asleep(asleep), .wake(wake), .irq(irq));
    analog_core_model analog_core_model_inst (.core_clk(core_clk), .powered(comparator_on),
        .use_int_ref(route_internal_ref), .plus_level(plus_level), .pin_level(pin_level),
        .ref_level(ref_level), .decision(cmp_raw));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = !core_clk;
    end

    // Watchdog, well past the test length
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic check(input byte_type got, input byte_type exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One write cycle
    task automatic reg_write(input logic [7:0] a, input byte_type d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // One read cycle; data taken in the following cycle only
    task automatic reg_read(input logic [7:0] a, input byte_type exp, input string what);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp, what);
    endtask

    // Control write, then the comparator response allowance
    task automatic set_ctrl(input byte_type d);
        reg_write(`OFS_COMPARATOR_CTRL, d);
        repeat (settle_cycles) @(posedge core_clk);
    endtask

    // Sleep entry pulse
    task automatic go_sleep();
        @(posedge core_clk);
        sleep_cmd <= 1'b1;
        @(posedge core_clk);
        sleep_cmd <= 1'b0;
        @(posedge core_clk);
        #1;
        check(byte_type'(asleep), 8'h01, "asleep");
    endtask

    // Bounded wait for the wake pulse
    task automatic wait_wake();
        seen = 1'b0;
        repeat (12)
        begin
            @(posedge core_clk);
            #1;
            if (wake === 1'b1)
                seen = 1'b1;
        end
    endtask

    // Counts and verdict
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        {nrst, dev_reset, reg_wr, reg_rd, sleep_cmd, pin_change, wdt_timeout} = '0;
        {timer_source_select, instr_tick, timer_clock_pin, reg_addr, reg_wdata} = '0;
        plus_level = 8'h80;
        pin_level = 8'h40;
        ref_level = 8'h20;
        repeat (20) @(posedge core_clk);
        check(byte_type'(comparator_on), 8'h00, "power in reset");
        check(byte_type'({asleep, wake, irq}), 8'h00, "outputs in reset");
        nrst <= 1'b1;
        repeat (settle_cycles) @(posedge core_clk);
        reg_read(`OFS_COMPARATOR_CTRL, 8'hff, "control at power-on");
        reg_read(`OFS_STATUS_FLAGS, 8'h18, "status at power-on");
        reg_read(8'h20, 8'h00, "unmapped");
        reg_read(`OFS_IRQ_STATUS, 8'h00, "irq status at power-on");
        // Result bit ignores writes, follows polarity and internal reference
        set_ctrl(8'hc8);
        reg_read(`OFS_COMPARATOR_CTRL, 8'h48, "inverted result");
        check(byte_type'({route_internal_ref, result_pin_oe}), 8'h02, "ref and pin");
        set_ctrl(8'h28);
        reg_read(`OFS_COMPARATOR_CTRL, 8'ha8, "plain result");
        check(byte_type'({result_pin_oe, result_pin_out}), 8'h03, "result pin");
        // Timer clock source table
        for (int i = 0; i < 5; i++)
        begin
            set_ctrl(t_ctl[i]);
            {timer_source_select, instr_tick, timer_clock_pin} <= t_sel[i][3:1];
            repeat (3) @(posedge core_clk);
            #1;
            check(byte_type'(timer_clock), byte_type'(t_sel[i][0]), "timer source");
        end
        // Comparator change wakes from sleep after a capture
        set_ctrl(8'h28);
        reg_write(`OFS_IRQ_ENABLE, 8'h07);
        reg_read(`OFS_COMPARATOR_CTRL, 8'ha8, "capture read");
        go_sleep();
        plus_level <= 8'h10;
        wait_wake();
        check(byte_type'({seen, asleep, irq}), 8'h05, "comparator wake");
        reg_read(`OFS_STATUS_FLAGS, 8'h50, "status after comparator wake");
        reg_read(`OFS_IRQ_STATUS, 8'h01, "irq status cmp");
        reg_write(`OFS_IRQ_CLEAR, 8'h01);
        @(posedge core_clk);
        #1;
        check(byte_type'(irq), 8'h00, "irq cleared");
        reg_write(`OFS_STATUS_FLAGS, 8'h00);
        reg_read(`OFS_STATUS_FLAGS, 8'h10, "wake flag cleared");
        // Wake disabled: change ignored, pin change wakes instead
        set_ctrl(8'h2b);
        reg_read(`OFS_COMPARATOR_CTRL, 8'h2b, "capture low result");
        go_sleep();
        plus_level <= 8'h80;
        wait_wake();
        check(byte_type'({seen, asleep, noninv_from_pin}), 8'h03, "no wake when disabled");
        pin_change <= 1'b1;
        wait_wake();
        pin_change <= 1'b0;
        check(byte_type'({seen, asleep}), 8'h02, "pin wake");
        reg_read(`OFS_STATUS_FLAGS, 8'h90, "status after pin wake");
        reg_write(`OFS_IRQ_CLEAR, 8'h07);
        // Other reset clears wake flags, powers down briefly, keeps control
        @(posedge core_clk);
        dev_reset <= 1'b1;
        @(posedge core_clk);
        dev_reset <= 1'b0;
        #1;
        check(byte_type'({comparator_on, noninv_from_pin}), 8'h00, "power in other reset");
        reg_read(`OFS_STATUS_FLAGS, 8'h10, "flags after other reset");
        reg_read(`OFS_COMPARATOR_CTRL, 8'hab, "control kept");
        // Watchdog wake with its interrupt masked, then unmasked
        reg_write(`OFS_IRQ_ENABLE, 8'h00);
        go_sleep();
        wdt_timeout <= 1'b1;
        wait_wake();
        wdt_timeout <= 1'b0;
        check(byte_type'({seen, irq}), 8'h02, "watchdog wake masked");
        reg_read(`OFS_IRQ_STATUS, 8'h04, "irq status wdt");
        reg_write(`OFS_IRQ_ENABLE, 8'h04);
        repeat (2) @(posedge core_clk);
        #1;
        check(byte_type'(irq), 8'h01, "irq unmasked");
        test_done();
    end
endmodule // comparator_control_wake_test
`default_nettype wire
